// >>> rtl/sap_params.svh
// Constants shared by both ends of the serial audio input link
`ifndef SAP_PARAMS_SVH
`define SAP_PARAMS_SVH

// --------------------------------------------------------------------
// System clock
// --------------------------------------------------------------------
`define SAP_CLK_HZ 50000000
`define SAP_CLK_NS 20

// --------------------------------------------------------------------
// Device register offsets and reset values
// --------------------------------------------------------------------
`define SAP_REG_FMT 8'h33
`define SAP_REG_OFS 8'h34
`define SAP_REG_CLKERR 8'h71
`define SAP_REG_ISTAT 8'h72
`define SAP_REG_IMASK 8'h73
`define SAP_FMT_RESET 8'h02
`define SAP_OFS_RESET 8'h00

// --------------------------------------------------------------------
// Format control fields
// --------------------------------------------------------------------
`define SAP_FMT_OFSHI 7
`define SAP_FMT_MODE_HI 5
`define SAP_FMT_MODE_LO 4
`define SAP_MODE_I2S 2'h0
`define SAP_MODE_TDM 2'h1
`define SAP_MODE_RJ 2'h2
`define SAP_MODE_LJ 2'h3
`define SAP_WL_16 2'h0
`define SAP_WL_20 2'h1
`define SAP_WL_24 2'h2
`define SAP_WL_32 2'h3

// --------------------------------------------------------------------
// Clock supervision
// --------------------------------------------------------------------
`define SAP_HALT_US 20
`define SAP_HALT_CYC (`SAP_HALT_US * (`SAP_CLK_HZ / 1000000))
`define SAP_RATE_MIN_HZ 24000
`define SAP_RATE_LO_HZ 40000
`define SAP_RATE_HI_HZ 70000
`define SAP_RATE_MAX_HZ 120000
`define SAP_CYC_MIN_RATE (`SAP_CLK_HZ / `SAP_RATE_MIN_HZ)
`define SAP_CYC_LO (`SAP_CLK_HZ / `SAP_RATE_LO_HZ)
`define SAP_CYC_HI (`SAP_CLK_HZ / `SAP_RATE_HI_HZ)
`define SAP_CYC_MAX_RATE (`SAP_CLK_HZ / `SAP_RATE_MAX_HZ)
`define SAP_RATE_32K 2'h0
`define SAP_RATE_48K 2'h1
`define SAP_RATE_96K 2'h2
`define SAP_RATE_BAD 2'h3

// --------------------------------------------------------------------
// Host controller
// --------------------------------------------------------------------
`define SAP_BCLK_NS 160
`define SAP_BCLK_HALF_CYC (`SAP_BCLK_NS / 2 / `SAP_CLK_NS)
`define SAP_RESTART_US 100
`define SAP_RESTART_CYC (`SAP_RESTART_US * (`SAP_CLK_HZ / 1000000))
`define SAP_H_CTRL 8'h00
`define SAP_H_LEFT 8'h04
`define SAP_H_RIGHT 8'h08
`define SAP_H_STAT 8'h0c
`define SAP_H_MASK 8'h10

`endif

// >>> rtl/sap_pkg.sv
// Types for the serial audio input link: device rate code and host state
`default_nettype none
package sap_pkg;
  typedef logic [1:0] sap_rate_t;
  typedef enum {host_idle, host_run} sap_host_state_t;
endpackage
`default_nettype wire

// >>> rtl/sap_link_if.sv
// Three-wire serial audio link between host and device
`default_nettype none
interface sap_link_if;
  logic bit_clk;
  logic word_clock_sync_pin;
  logic serial_data_input;
  modport host (output bit_clk, output word_clock_sync_pin, output serial_data_input);
  modport dev (input bit_clk, input word_clock_sync_pin, input serial_data_input);
endinterface
`default_nettype wire

// >>> rtl/sap_device.sv
// Device end: serial audio receiver with clock supervision and registers
//
// Our own choice: the address-and-strobe port.
`include "sap_params.svh"
`default_nettype none

// Notes on behaviour
// - Data bit taken on bit clock rise
// - Bit clock is the only timing reference
// - Detect 32k, 48k, 96k class sample rate
// - Allowed formats, word lengths and clock ratios
// - Halt or bad ratio sets clock error
// - Halt forces hi-z, resumes state afterwards
// - Host halts clocks 100 us before rate change
// - Host gives stable clocks before register setup
// - Format select from control bits 5..4
// - Twos complement words, MSB first, up to 32
// - Word length from control bits 1..0
// - Offset from control bit 7 and offset register
// - Reset default is I2S, 24 bit
// - TDM sync rising edge starts a frame
// - I2S: word clock low left, high right
// - Right justified: high left, low right
module sap_device (
  input wire logic clock_i,
  input wire logic resetn_i,
  sap_link_if.dev link,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic [31:0] left_o,
  output logic [31:0] right_o,
  output logic sample_valid_o,
  output logic channel_hiz_o,
  output sap_pkg::sap_rate_t rate_code_o,
  output logic irq_o
);
  import sap_pkg::*;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic bclk_s1, bclk_s2, bclk_s3;
  logic wclk_s1, wclk_s2;
  logic sd_s1, sd_s2;
  // All port timing is taken from bit clock edges, no other audio clock exists
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      {bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
      {wclk_s1, wclk_s2, sd_s1, sd_s2} <= 4'h0;
    end else begin
      bclk_s1 <= link.bit_clk;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      wclk_s1 <= link.word_clock_sync_pin;
      wclk_s2 <= wclk_s1;
      sd_s1 <= link.serial_data_input;
      sd_s2 <= sd_s1;
    end
  end
  logic bclk_rise;
  assign bclk_rise = bclk_s2 & ~bclk_s3;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0] fmt, ofs, istat, imask, rdata;
  logic wclk_prev, halted, first_frame, ratio_bad, err, valid, irq;
  logic [9:0] cnt, frame_cnt, frame_bits;
  logic [11:0] cyc_cnt;
  logic [10:0] halt_cnt;
  logic [31:0] shreg, left, right;
  sap_rate_t rate;
  logic [7:0] next_fmt, next_ofs, next_istat, next_imask, next_rdata;
  logic next_wclk_prev, next_halted, next_first_frame, next_ratio_bad, next_err, next_valid, next_irq;
  logic [9:0] next_cnt, next_frame_cnt, next_frame_bits;
  logic [11:0] next_cyc_cnt;
  logic [10:0] next_halt_cnt;
  logic [31:0] next_shreg, next_left, next_right;
  sap_rate_t next_rate;

  function automatic logic [5:0] wl_bits(input logic [1:0] code);
    case (code)
      `SAP_WL_16: wl_bits = 6'd16;
      `SAP_WL_20: wl_bits = 6'd20;
      `SAP_WL_24: wl_bits = 6'd24;
      default: wl_bits = 6'd32;
    endcase
  endfunction

  // Frame ratio check per format and detected rate
  function automatic logic ratio_ok(input logic [1:0] mode, input logic [9:0] bits, input sap_rate_t r);
    if (mode != `SAP_MODE_TDM) begin
      ratio_ok = (bits == 10'd32) || (bits == 10'd64);
    end else begin
      ratio_ok = (bits == 10'd128) || ((bits == 10'd256) && (r != `SAP_RATE_32K))
        || ((bits == 10'd512) && (r == `SAP_RATE_48K));
    end
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  logic [1:0] mode;
  logic [10:0] wl11, off11, half11, idx, st;
  logic slot_start, frame_start, in_win, is_right, last_bit;
  logic [31:0] word;
  logic err_rise, err_fall;
  always_comb begin
    mode = fmt[`SAP_FMT_MODE_HI:`SAP_FMT_MODE_LO];
    wl11 = {5'h0, wl_bits(fmt[1:0])};
    off11 = {2'h0, fmt[`SAP_FMT_OFSHI], ofs};
    half11 = {2'h0, frame_bits[9:1]};
    frame_start = wclk_s2 & ~wclk_prev;
    slot_start = (mode == `SAP_MODE_TDM) ? frame_start : (wclk_s2 != wclk_prev);
    idx = slot_start ? 11'h0 : ((cnt == 10'h3ff) ? {1'b0, cnt} : {1'b0, cnt} + 11'h1);
    st = off11;
    in_win = 1'b0;
    is_right = 1'b0;
    if (mode == `SAP_MODE_TDM) begin
      if (idx >= off11 && idx < off11 + wl11) begin
        in_win = 1'b1;
      end else if (idx >= off11 + wl11 && idx < off11 + wl11 + wl11) begin
        in_win = 1'b1;
        is_right = 1'b1;
        st = off11 + wl11;
      end
    end else begin
      if (mode == `SAP_MODE_I2S) begin
        st = off11 + 11'h1;
        is_right = wclk_s2;
      end else begin
        if (mode == `SAP_MODE_RJ) begin
          st = (half11 >= wl11 + off11) ? half11 - wl11 - off11 : 11'h0;
        end
        is_right = ~wclk_s2;
      end
      in_win = (idx >= st) && (idx < st + wl11);
    end
    last_bit = in_win && (idx == st + wl11 - 11'h1);
    next_shreg = shreg;
    next_left = left;
    next_right = right;
    next_valid = 1'b0;
    next_wclk_prev = wclk_prev;
    next_cnt = cnt;
    next_frame_cnt = frame_cnt;
    next_frame_bits = frame_bits;
    next_first_frame = first_frame;
    next_ratio_bad = ratio_bad;
    next_rate = rate;
    next_cyc_cnt = (cyc_cnt == 12'hfff) ? cyc_cnt : cyc_cnt + 12'h1;
    next_halt_cnt = (halt_cnt == 11'(`SAP_HALT_CYC)) ? halt_cnt : halt_cnt + 11'h1;
    next_halted = halted;
    word = 32'h0;
    if (bclk_rise) begin
      next_halt_cnt = 11'h0;
      next_halted = 1'b0;
      if (halted) begin
        next_first_frame = 1'b1;
      end
      next_wclk_prev = wclk_s2;
      next_cnt = idx[9:0];
      if (in_win) begin
        next_shreg = {shreg[30:0], sd_s2};
      end
      // Words are left aligned so the sign bit lands in bit 31
      word = next_shreg << (6'd32 - wl11[5:0]);
      if (last_bit && is_right) begin
        next_right = word;
        next_valid = ~halted & ~first_frame;
      end else if (last_bit) begin
        next_left = word;
      end
      if (frame_start) begin
        next_frame_cnt = 10'h0;
        next_frame_bits = frame_cnt + 10'h1;
        next_cyc_cnt = 12'h0;
        if (cyc_cnt > 12'(`SAP_CYC_MIN_RATE) || cyc_cnt < 12'(`SAP_CYC_MAX_RATE)) begin
          next_rate = `SAP_RATE_BAD;
        end else if (cyc_cnt > 12'(`SAP_CYC_LO)) begin
          next_rate = `SAP_RATE_32K;
        end else if (cyc_cnt > 12'(`SAP_CYC_HI)) begin
          next_rate = `SAP_RATE_48K;
        end else begin
          next_rate = `SAP_RATE_96K;
        end
        // The frame after a halt is partial, so its length is not judged
        if (!first_frame) begin
          next_ratio_bad = ~ratio_ok(mode, frame_cnt + 10'h1, next_rate);
        end
        next_first_frame = 1'b0;
      end else if (frame_cnt == 10'h3ff) begin
        next_ratio_bad = 1'b1;
      end else begin
        next_frame_cnt = frame_cnt + 10'h1;
      end
    end else if (halt_cnt == 11'(`SAP_HALT_CYC)) begin
      next_halted = 1'b1;
    end
    // Level tracks the conditions, so it drops once clocks are good
    next_err = halted | ratio_bad | (rate == `SAP_RATE_BAD);
    err_rise = next_err & ~err;
    err_fall = ~next_err & err;

    // Register port
    next_fmt = fmt;
    next_ofs = ofs;
    next_imask = imask;
    next_istat = istat;
    if (reg_wr_i) begin
      if (reg_addr_i == `SAP_REG_FMT) begin
        next_fmt = reg_wdata_i;
      end else if (reg_addr_i == `SAP_REG_OFS) begin
        next_ofs = reg_wdata_i;
      end else if (reg_addr_i == `SAP_REG_IMASK) begin
        next_imask = reg_wdata_i;
      end else if (reg_addr_i == `SAP_REG_ISTAT) begin
        next_istat = istat & ~reg_wdata_i;
      end
    end
    // Set wins over a clear in the same cycle
    next_istat = next_istat | {5'h0, next_valid, err_fall, err_rise};
    next_irq = |(istat & imask);
    next_rdata = 8'h0;
    if (reg_rd_i) begin
      if (reg_addr_i == `SAP_REG_FMT) begin
        next_rdata = fmt;
      end else if (reg_addr_i == `SAP_REG_OFS) begin
        next_rdata = ofs;
      end else if (reg_addr_i == `SAP_REG_CLKERR) begin
        next_rdata = {3'h0, rate, ratio_bad, halted, err};
      end else if (reg_addr_i == `SAP_REG_ISTAT) begin
        next_rdata = istat;
      end else if (reg_addr_i == `SAP_REG_IMASK) begin
        next_rdata = imask;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      fmt <= `SAP_FMT_RESET;
      ofs <= `SAP_OFS_RESET;
      istat <= 8'h0;
      imask <= 8'h0;
      rdata <= 8'h0;
      wclk_prev <= 1'b0;
      halted <= 1'b1;
      first_frame <= 1'b1;
      ratio_bad <= 1'b0;
      err <= 1'b1;
      valid <= 1'b0;
      irq <= 1'b0;
      cnt <= 10'h0;
      frame_cnt <= 10'h0;
      frame_bits <= 10'h0;
      cyc_cnt <= 12'h0;
      halt_cnt <= 11'h0;
      shreg <= 32'h0;
      left <= 32'h0;
      right <= 32'h0;
      rate <= `SAP_RATE_BAD;
    end else begin
      fmt <= next_fmt;
      ofs <= next_ofs;
      istat <= next_istat;
      imask <= next_imask;
      rdata <= next_rdata;
      wclk_prev <= next_wclk_prev;
      halted <= next_halted;
      first_frame <= next_first_frame;
      ratio_bad <= next_ratio_bad;
      err <= next_err;
      valid <= next_valid;
      irq <= next_irq;
      cnt <= next_cnt;
      frame_cnt <= next_frame_cnt;
      frame_bits <= next_frame_bits;
      cyc_cnt <= next_cyc_cnt;
      halt_cnt <= next_halt_cnt;
      shreg <= next_shreg;
      left <= next_left;
      right <= next_right;
      rate <= next_rate;
    end
  end

  assign reg_rdata_o = rdata;
  assign left_o = left;
  assign right_o = right;
  assign sample_valid_o = valid;
  assign channel_hiz_o = halted;
  assign rate_code_o = rate;
  assign irq_o = irq;
endmodule // sap_device
`default_nettype wire

// >>> rtl/sap_host.sv
// Host end: drives bit clock, word clock and serial data from registers
`include "sap_params.svh"
`default_nettype none
module sap_host #(
  parameter int RESTART_CYCLES = `SAP_RESTART_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  sap_link_if.host link,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [31:0] cmd_wdata_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  output logic [31:0] cmd_rdata_o,
  output logic irq_o
);
  import sap_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  sap_host_state_t state, next_state;
  logic [7:0] ctrl, next_ctrl;
  logic [31:0] lreg, rreg, lsh, rsh, rdata;
  logic [31:0] next_lreg, next_rreg, next_lsh, next_rsh, next_rdata;
  logic [2:0] div, next_div;
  logic [9:0] b, next_b;
  logic [12:0] hcnt, next_hcnt;
  logic bclk, wclk, sd, stat, mask, stable, irq;
  logic next_bclk, next_wclk, next_sd, next_stat, next_mask, next_stable, next_irq;

  // Pin values for bit index n of the frame
  function automatic logic [1:0] pins(input logic [1:0] mode, input logic [9:0] n, input logic [9:0] nb,
                                      input logic [1:0] wlc, input logic [31:0] lw, input logic [31:0] rw);
    logic [9:0] half, wl, pos, i;
    logic ch, w, ok;
    half = {1'b0, nb[9:1]};
    wl = (wlc == `SAP_WL_16) ? 10'd16 : (wlc == `SAP_WL_20) ? 10'd20 : (wlc == `SAP_WL_24) ? 10'd24 : 10'd32;
    ch = (n >= half);
    pos = ch ? n - half : n;
    w = ~ch;
    i = pos;
    ok = 1'b1;
    if (mode == `SAP_MODE_I2S) begin
      w = ch;
      ok = (pos != 10'h0);
      i = pos - 10'h1;
    end else if (mode == `SAP_MODE_RJ) begin
      ok = (pos + wl >= half);
      i = pos + wl - half;
    end else if (mode == `SAP_MODE_TDM) begin
      // One bit wide sync pulse, left then right slot
      w = (n == 10'h0);
      ch = (n >= wl);
      i = ch ? n - wl : n;
    end
    ok = ok && (i < wl);
    pins = {w, ok ? (ch ? rw[5'd31 - i[4:0]] : lw[5'd31 - i[4:0]]) : 1'b0};
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  logic [9:0] nbits, nb_next;
  logic [1:0] pv;
  logic fall;
  always_comb begin
    nbits = 10'd32 << ctrl[5:3];
    next_state = state;
    next_div = div;
    next_b = b;
    next_bclk = bclk;
    next_wclk = wclk;
    next_sd = sd;
    next_lsh = lsh;
    next_rsh = rsh;
    next_stable = stable;
    next_hcnt = hcnt;
    next_stat = stat;
    fall = 1'b0;
    nb_next = 10'h0;
    pv = 2'h0;
    case (state)
      host_idle: begin
        next_bclk = 1'b0;
        next_wclk = 1'b0;
        next_sd = 1'b0;
        next_hcnt = (hcnt == 13'(RESTART_CYCLES)) ? hcnt : hcnt + 13'h1;
        // Clocks stay halted long enough before a new rate starts
        if (ctrl[0] && hcnt == 13'(RESTART_CYCLES)) begin
          next_state = host_run;
          next_div = 3'h0;
          next_b = 10'h0;
          next_lsh = lreg;
          next_rsh = rreg;
          pv = pins(ctrl[2:1], 10'h0, nbits, ctrl[7:6], lreg, rreg);
          next_wclk = pv[1];
          next_sd = pv[0];
        end
      end
      host_run: begin
        if (!ctrl[0]) begin
          next_state = host_idle;
          next_hcnt = 13'h0;
          next_stable = 1'b0;
          next_bclk = 1'b0;
          next_wclk = 1'b0;
          next_sd = 1'b0;
        end else if (div == 3'(`SAP_BCLK_HALF_CYC - 1)) begin
          next_div = 3'h0;
          next_bclk = ~bclk;
          fall = bclk;
        end else begin
          next_div = div + 3'h1;
        end
        // Data and word clock move on the falling edge, the device samples on the rise
        if (fall) begin
          nb_next = (b >= nbits - 10'h1) ? 10'h0 : b + 10'h1;
          next_b = nb_next;
          if (nb_next == 10'h0) begin
            next_lsh = lreg;
            next_rsh = rreg;
            next_stat = 1'b1;
            next_stable = 1'b1;
          end
          pv = pins(ctrl[2:1], nb_next, nbits, ctrl[7:6], next_lsh, next_rsh);
          next_wclk = pv[1];
          next_sd = pv[0];
        end
      end
      default: next_state = host_idle;
    endcase

    next_ctrl = ctrl;
    next_lreg = lreg;
    next_rreg = rreg;
    next_mask = mask;
    if (cmd_wr_i) begin
      if (cmd_addr_i == `SAP_H_CTRL) begin
        next_ctrl = cmd_wdata_i[7:0];
      end else if (cmd_addr_i == `SAP_H_LEFT) begin
        next_lreg = cmd_wdata_i;
      end else if (cmd_addr_i == `SAP_H_RIGHT) begin
        next_rreg = cmd_wdata_i;
      end else if (cmd_addr_i == `SAP_H_STAT) begin
        next_stat = next_stat & ~cmd_wdata_i[0] | (fall && nb_next == 10'h0);
      end else if (cmd_addr_i == `SAP_H_MASK) begin
        next_mask = cmd_wdata_i[0];
      end
    end
    next_irq = stat & mask;
    next_rdata = 32'h0;
    if (cmd_rd_i) begin
      if (cmd_addr_i == `SAP_H_CTRL) begin
        next_rdata = {24'h0, ctrl};
      end else if (cmd_addr_i == `SAP_H_LEFT) begin
        next_rdata = lreg;
      end else if (cmd_addr_i == `SAP_H_RIGHT) begin
        next_rdata = rreg;
      end else if (cmd_addr_i == `SAP_H_STAT) begin
        next_rdata = {30'h0, stable, stat};
      end else if (cmd_addr_i == `SAP_H_MASK) begin
        next_rdata = {31'h0, mask};
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= host_idle;
      ctrl <= 8'h0;
      lreg <= 32'h0;
      rreg <= 32'h0;
      lsh <= 32'h0;
      rsh <= 32'h0;
      rdata <= 32'h0;
      div <= 3'h0;
      b <= 10'h0;
      hcnt <= 13'h0;
      {bclk, wclk, sd, stat, mask, stable, irq} <= 7'h0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      lreg <= next_lreg;
      rreg <= next_rreg;
      lsh <= next_lsh;
      rsh <= next_rsh;
      rdata <= next_rdata;
      div <= next_div;
      b <= next_b;
      hcnt <= next_hcnt;
      {bclk, wclk, sd, stat, mask, stable, irq} <=
        {next_bclk, next_wclk, next_sd, next_stat, next_mask, next_stable, next_irq};
    end
  end

  assign link.bit_clk = bclk;
  assign link.word_clock_sync_pin = wclk;
  assign link.serial_data_input = sd;
  assign cmd_rdata_o = rdata;
  assign irq_o = irq;
endmodule // sap_host
`default_nettype wire

// >>> tb/sap_chk.sv
// Wire checker for the serial audio link between host and device
`default_nettype none
module sap_chk #(
  parameter int RESTART_CYCLES = 5000
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic bit_clk,
  input wire logic word_clock_sync_pin,
  input wire logic serial_data_input
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Idle count saturates so a long halt never wraps into a fake short gap
  logic [15:0] idle, next_idle;
  logic [9:0] rises, next_rises;
  logic ok, next_ok, pb, pw;
  always_comb begin
    next_idle = (bit_clk != pb) ? 16'h0 : idle + {15'h0, ~&idle};
    next_rises = (word_clock_sync_pin && !pw) ? 10'h0 : rises + {9'h0, bit_clk && !pb};
    next_ok = (idle > 16'h8) ? 1'b0 : (ok || (word_clock_sync_pin && !pw));
  end
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      idle <= 16'h0;
      rises <= 10'h0;
      ok <= 1'b0;
      pb <= 1'b0;
      pw <= 1'b0;
    end else begin
      idle <= next_idle;
      rises <= next_rises;
      ok <= next_ok;
      pb <= bit_clk;
      pw <= word_clock_sync_pin;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  bclk_high_a: assert property ($rose(bit_clk) |-> bit_clk [*4])
    else $error("bit clock high phase short");
  bclk_low_a: assert property ($fell(bit_clk) |-> !bit_clk [*4])
    else $error("bit clock low phase short");
  data_hold_a: assert property ($rose(bit_clk) |-> $stable(serial_data_input) [*3])
    else $error("data moved near bit clock rise");
  wclk_hold_a: assert property ($rose(bit_clk) |-> $stable(word_clock_sync_pin) [*3])
    else $error("word clock moved near bit clock rise");
  data_edge_a: assert property ($changed(serial_data_input) |-> !bit_clk)
    else $error("data changed while bit clock high");
  sync_width_a: assert property ($rose(word_clock_sync_pin) |-> word_clock_sync_pin [*8])
    else $error("frame sync narrower than one bit clock");
  frame_len_a: assert property ($rose(word_clock_sync_pin) && ok |-> rises inside {10'd32, 10'd64, 10'd128, 10'd256, 10'd512})
    else $error("frame length not allowed");
  restart_gap_a: assert property ($rose(bit_clk) && idle > 16'h8 |-> int'(idle) >= RESTART_CYCLES - 2)
    else $error("clocks restarted too soon after halt");
  cover property ($rose(word_clock_sync_pin) && ok);
  cover property ($rose(bit_clk) && idle > 16'h8);
  cover property ($fell(word_clock_sync_pin) && rises > 10'd100);
endmodule // sap_chk
`default_nettype wire

// >>> tb/sap_bench.sv
// Self-checking bench joining host and device ends of the audio link
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module sap_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sap_pkg::*;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  // Restart gap kept above the halt detect time so every stop is seen as a halt
  localparam int RST = 1200;
  logic clock_i = 1'b0, resetn_i = 1'b0, d_wr = 1'b0, d_rd = 1'b0, h_wr = 1'b0, h_rd = 1'b0;
  logic [7:0] d_addr = 8'h0, d_wdata = 8'h0, h_addr = 8'h0, d_rdata, rd8;
  logic [31:0] h_wdata = 32'h0, h_rdata, left, right, rd32;
  logic valid, hiz, dirq, hirq;
  sap_rate_t rate;
  int n_errors = 0, checks = 0, cyc = 0;
  always #10 clock_i = ~clock_i;
  sap_link_if lnk ();
  sap_host #(.RESTART_CYCLES(RST)) sap_host_i (.clock_i(clock_i), .resetn_i(resetn_i), .link(lnk.host),
    .cmd_addr_i(h_addr), .cmd_wdata_i(h_wdata), .cmd_wr_i(h_wr), .cmd_rd_i(h_rd), .cmd_rdata_o(h_rdata), .irq_o(hirq));
  sap_device sap_device_i (.clock_i(clock_i), .resetn_i(resetn_i), .link(lnk.dev), .reg_addr_i(d_addr),
    .reg_wdata_i(d_wdata), .reg_wr_i(d_wr), .reg_rd_i(d_rd), .reg_rdata_o(d_rdata), .left_o(left), .right_o(right),
    .sample_valid_o(valid), .channel_hiz_o(hiz), .rate_code_o(rate), .irq_o(dirq));
  sap_chk #(.RESTART_CYCLES(RST)) sap_chk_i (.clock_i(clock_i), .resetn_i(resetn_i), .bit_clk(lnk.bit_clk),
    .word_clock_sync_pin(lnk.word_clock_sync_pin), .serial_data_input(lnk.serial_data_input));
  task automatic dwr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    d_addr <= a;
    d_wdata <= v;
    d_wr <= 1'b1;
    @(posedge clock_i);
    d_wr <= 1'b0;
  endtask
  task automatic drd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    d_addr <= a;
    d_rd <= 1'b1;
    @(posedge clock_i);
    d_rd <= 1'b0;
    @(negedge clock_i);
    v = d_rdata;
  endtask
  task automatic hwr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    h_addr <= a;
    h_wdata <= v;
    h_wr <= 1'b1;
    @(posedge clock_i);
    h_wr <= 1'b0;
  endtask
  task automatic hrd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge clock_i);
    h_rd <= 1'b0;
    @(negedge clock_i);
    v = h_rdata;
  endtask
  // Stop one bit clock after a frame start, in the low phase, so the sync pulse or word clock high level lasts at least one bit clock
  task automatic hstop();
    @(posedge lnk.word_clock_sync_pin);
    @(negedge clock_i);
    @(negedge lnk.bit_clk);
    hwr(8'h00, 32'h0);
  endtask
  task automatic wvalid(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 8000) begin
      @(negedge clock_i);
      k++;
      if (valid === 1'b1) n--;
    end
    `CHK(n, 0)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      summarize();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [1:0] md [4];
    logic [1:0] er;
    int wl;
    md = '{2'h0, 2'h2, 2'h3, 2'h1};
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    drd(8'h33, rd8); `CHK(rd8, 8'h02)
    `CHK(hiz, 1'b1)
    drd(8'h71, rd8); `CHK({rd8[4:3], rd8[0]}, 3'b111)
    drd(8'h50, rd8); `CHK(rd8, 8'h00)
    dwr(8'h33, 8'hbf);
    dwr(8'h34, 8'h5a);
    dwr(8'h71, 8'h00);
    drd(8'h33, rd8); `CHK(rd8, 8'hbf)
    drd(8'h34, rd8); `CHK(rd8, 8'h5a)
    drd(8'h71, rd8); `CHK(rd8[0], 1'b1)
    dwr(8'h34, 8'h00);
    hwr(8'h04, 32'ha5a5a5a5);
    hwr(8'h08, 32'h3c3c3c3c);
    hwr(8'h10, 32'h1);
    hrd(8'h04, rd32); `CHK(rd32, 32'ha5a5a5a5)
    `CHK(dirq, 1'b0)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      er = (md[i] == 2'h1) ? 2'h1 : 2'h2;
      // Word length code follows the mode code, so every length is exercised once
      wl = (md[i] == 2'h3) ? 32 : 16 + 4 * md[i];
      dwr(8'h33, {2'b00, md[i], (md[i] == 2'h1) ? 2'b01 : 2'b00, md[i]});
      hwr(8'h00, {24'h0, md[i], (md[i] == 2'h1) ? 3'h2 : 3'h1, md[i], 1'b1});
      wvalid(3);
      `CHK(left, 32'ha5a5a5a5 & ~(32'hffffffff >> wl))
      `CHK(right, 32'h3c3c3c3c & ~(32'hffffffff >> wl))
      `CHK(rate, er)
      `CHK(hiz, 1'b0)
      `CHK(hirq, 1'b1)
      drd(8'h71, rd8); `CHK(rd8, {3'b000, er, 3'b000})
      hrd(8'h0c, rd32); `CHK(rd32[1:0], 2'b11)
      hstop();
      repeat (1100) @(posedge clock_i);
      `CHK(hiz, 1'b1)
      drd(8'h71, rd8); `CHK(rd8[1:0], 2'b11)
      hrd(8'h0c, rd32); `CHK(rd32[1], 1'b0)
      $display("test mode %0d done", md[i]);
    end
    // A 128 bit frame is not allowed outside the time slot format
    dwr(8'h33, 8'h00);
    hwr(8'h00, 32'h11);
    repeat (3000) @(posedge clock_i);
    drd(8'h71, rd8); `CHK(rd8, 8'h0d)
    hstop();
    $display("test bad ratio done");
    hwr(8'h0c, 32'h1);
    repeat (3) @(negedge clock_i);
    `CHK(hirq, 1'b0)
    dwr(8'h73, 8'h01);
    repeat (3) @(negedge clock_i);
    `CHK(dirq, 1'b1)
    drd(8'h72, rd8); `CHK(rd8, 8'h07)
    dwr(8'h72, 8'h01);
    drd(8'h72, rd8); `CHK(rd8, 8'h06)
    repeat (3) @(negedge clock_i);
    `CHK(dirq, 1'b0)
    $display("test interrupts done");
    summarize();
  end
endmodule // sap_bench
`default_nettype wire
